// ### hsni_pkg.sv
// Package for the host-side node interrupt and status block.
// Assumes a single 40 MHz system clock shared by every user of these names.
package hsni_pkg;

  // Byte offsets inside the node register space
  localparam logic [5:0] OFF_LOCAL_COMMAND     = 6'h00;
  localparam logic [5:0] OFF_INTERRUPT_CONTROL = 6'h01;
  localparam logic [5:0] OFF_LOCAL_STATUS      = 6'h02;
  localparam logic [5:0] OFF_CABLE_PENDING     = 6'h03;
  localparam logic [5:0] OFF_LOCAL_END         = 6'h08;
  localparam logic [5:0] OFF_REMOTE_NODE       = 6'h08;
  localparam logic [5:0] OFF_REMOTE_END        = 6'h10;
  localparam logic [5:0] OFF_SPACE_END         = 6'h28;

  // Local command fields
  localparam int CMD_CLR_STATUS_BIT   = 7;
  localparam int CMD_CLR_DOORBELL_BIT = 6;
  localparam int CMD_SEND_DOORBELL_BIT = 5;

  // Interrupt control fields
  localparam int ICR_ACTIVE_BIT     = 7;
  localparam int ICR_NORMAL_EN_BIT  = 6;
  localparam int ICR_ERROR_EN_BIT   = 5;
  localparam int ICR_SEL_MSB        = 2;

  // Local status fields
  localparam int STS_LINK_ERR_BIT   = 7;
  localparam int STS_BUS_ERR_BIT    = 6;
  localparam int STS_DOORBELL_BIT   = 5;
  localparam int STS_TIMEOUT_BIT    = 2;
  localparam int STS_REMOTE_OFF_BIT = 0;

  // Reset values
  localparam logic       RST_SEND_DOORBELL = 1'b0;
  localparam logic       RST_NORMAL_EN     = 1'b0;
  localparam logic       RST_ERROR_EN      = 1'b0;
  localparam logic [2:0] RST_LINE_SELECT   = 3'h0;

  // Interface timeout: 30 us at 40 MHz
  localparam int TMO_TIME_US = 30;
  localparam int CLK_MHZ     = 40;
  localparam int TMO_CYC     = TMO_TIME_US * CLK_MHZ;
  localparam int TMO_W       = 11;

  // Host request carried as one unit
  typedef struct packed {
    logic        wr;
    logic [5:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } hsni_req_t;

  // Remote access sequencer
  typedef enum logic [1:0] {
    RA_IDLE = 2'b00,
    RA_WAIT = 2'b01,
    RA_REL  = 2'b11
  } hsni_ra_t;

endpackage : hsni_pkg

// ### hsni_tmo.sv
// Interface timeout counter for remote accesses.
// Assumes run_i is a level from the same clock that stays high while waiting.
`timescale 1ns/10ps
`default_nettype none
module hsni_tmo (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Control
  input  wire logic run_i,
  output logic      expire_o
);
  import hsni_pkg::*;

  localparam logic [TMO_W-1:0] LAST = TMO_W'(TMO_CYC - 1);

  logic [TMO_W-1:0] cnt_r;

  // Count waiting cycles; restart whenever the wait ends
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      if (!run_i) begin
        cnt_r <= '0;
      end else if (cnt_r != LAST) begin
        cnt_r <= cnt_r + TMO_W'(1);
      end
    end
  end

  // One pulse when the full window has passed
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      expire_o <= 1'b0;
    end else if (ce_i) begin
      expire_o <= run_i && (cnt_r == LAST - TMO_W'(1)) && !expire_o;
    end
  end

endmodule : hsni_tmo
`default_nettype wire

// ### hsni_top.sv
// Host-side local node registers: doorbells, cable interrupt routing,
// link error flags, interface timeout and the host interrupt.
// Assumes remote and cable pins are asynchronous; DMA inputs share sys_clk_i.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Byte or word access only, no longword
// - 40-byte space; local bytes here, remote forwarded
// - Command bit 7 clears all error flags
// - Command bit 6 clears inbound doorbell flag
// - Command bit 5 drives outbound doorbell level
// - Control bit 7 reads host interrupt active
// - Control bit 6 gates normal sources
// - Control bit 5 gates error sources
// - Select field routes doorbell to line 1-7
// - Status bit 7 latches link data error
// - Status bit 6 latches remote bus error
// - Status bit 5 latches inbound doorbell
// - 30 us no response sets timeout flag
// - Status bit 0 shows remote down, live
// - Pending bits 7-1 show cable lines
// - Cable lines mirror remote bus interrupts
module hsni_top (
  // Clock, reset, enable
  input  wire logic               sys_clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  // Host register window
  input  wire logic               host_valid_i,
  input  wire hsni_pkg::hsni_req_t host_req_i,
  output logic [15:0]             host_rdata_o,
  output logic                    host_ack_o,
  output logic                    host_err_o,
  output logic                    host_irq_o,
  // Remote node access over the cable
  output logic                    remote_req_o,
  output logic                    remote_wr_o,
  output logic [2:0]              remote_addr_o,
  output logic [1:0]              remote_be_o,
  output logic [15:0]             remote_wdata_o,
  input  wire logic               remote_ack_i,
  input  wire logic [15:0]        remote_rdata_i,
  // Remote events and state pins
  input  wire logic               link_data_err_i,
  input  wire logic               remote_bus_err_i,
  input  wire logic               inbound_doorbell_interrupt_i,
  input  wire logic               remote_power_off_i,
  input  wire logic               cable_absent_i,
  input  wire logic               remote_reset_i,
  input  wire logic [7:1]         cable_interrupt_line_i,
  output logic [7:1]              cable_interrupt_line_o,
  // Local DMA controller, same clock
  input  wire logic               dma_done_i,
  input  wire logic               dma_check_error_i
);
  import hsni_pkg::*;

  localparam int PIN_W = 13;

  // Byte lane hit for one register offset
  function automatic logic lane_hit(input hsni_req_t r, input logic [5:0] off);
    lane_hit = (r.addr[5:1] == off[5:1]) && r.be[off[0]];
  endfunction : lane_hit

  // Byte of write data that belongs to one offset
  function automatic logic [7:0] lane_byte(input hsni_req_t r, input logic [5:0] off);
    lane_byte = off[0] ? r.wdata[15:8] : r.wdata[7:0];
  endfunction : lane_byte

  // Address falls inside [lo, hi)
  function automatic logic in_range(input logic [5:0] a, input logic [5:0] lo,
                                    input logic [5:0] hi);
    in_range = (a >= lo) && (a < hi);
  endfunction : in_range

  // Pin synchronisers
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic [2:0]       evt_d_r;
  logic             ack_s1_r;
  logic             ack_s2_r;
  logic [15:0]      rdat_s1_r;
  logic [15:0]      rdat_s2_r;

  // Register state
  logic             send_doorbell_r;
  logic             normal_en_r;
  logic             error_en_r;
  logic [2:0]       line_sel_r;
  logic             link_err_r;
  logic             bus_err_r;
  logic             doorbell_r;
  logic             timeout_r;

  // Remote access state
  hsni_ra_t         ra_state_r;
  hsni_ra_t         ra_state_nxt;
  logic             expire;

  // Decoded signals
  logic             take;
  logic             wr_take;
  logic             cmd_wr;
  logic [7:0]       cmd_byte;
  logic             icr_wr;
  logic [7:0]       icr_byte;
  logic             is_local;
  logic             is_remote;
  logic             is_space;
  logic             remote_off;
  logic [7:1]       pending;
  logic             link_err_evt;
  logic             bus_err_evt;
  logic             doorbell_evt;
  logic             clr_status;
  logic             clr_doorbell;
  logic             tmo_set;
  logic             normal_src;
  logic             error_src;
  logic [7:0]       rd_cmd;
  logic [7:0]       rd_icr;
  logic [7:0]       rd_sts;
  logic [7:0]       rd_pend;

  // Two flops on every pin before use; stage one feeds stage two only
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else if (ce_i) begin
      pin_s1_r <= {cable_interrupt_line_i, remote_reset_i, cable_absent_i,
                   remote_power_off_i, inbound_doorbell_interrupt_i,
                   remote_bus_err_i, link_data_err_i};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Previous synchronised event levels for rising edge detection
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_d_r <= '0;
    end else if (ce_i) begin
      evt_d_r <= pin_s2_r[2:0];
    end
  end

  // Remote answer synchronisers; data settles before the ack edge arrives
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_s1_r  <= 1'b0;
      ack_s2_r  <= 1'b0;
      rdat_s1_r <= '0;
      rdat_s2_r <= '0;
    end else if (ce_i) begin
      ack_s1_r  <= remote_ack_i;
      ack_s2_r  <= ack_s1_r;
      rdat_s1_r <= remote_rdata_i;
      rdat_s2_r <= rdat_s1_r;
    end
  end

  // Event and level decode from the synchronised pins
  assign link_err_evt = pin_s2_r[0] && !evt_d_r[0];
  assign bus_err_evt  = pin_s2_r[1] && !evt_d_r[1];
  assign doorbell_evt = pin_s2_r[2] && !evt_d_r[2];
  assign remote_off   = |pin_s2_r[5:3];
  assign pending      = pin_s2_r[PIN_W-1:6];

  // Request decode; a request is only taken while no remote access runs
  assign take      = host_valid_i && (ra_state_r == RA_IDLE);
  assign wr_take   = take && host_req_i.wr;
  assign is_local  = in_range(host_req_i.addr, OFF_LOCAL_COMMAND, OFF_LOCAL_END);
  assign is_remote = in_range(host_req_i.addr, OFF_REMOTE_NODE, OFF_REMOTE_END);
  assign is_space  = in_range(host_req_i.addr, OFF_LOCAL_COMMAND, OFF_SPACE_END);

  // Per-register write strobes from byte lanes; a word covers two offsets
  assign cmd_wr   = wr_take && lane_hit(host_req_i, OFF_LOCAL_COMMAND);
  assign cmd_byte = lane_byte(host_req_i, OFF_LOCAL_COMMAND);
  assign icr_wr   = wr_take && lane_hit(host_req_i, OFF_INTERRUPT_CONTROL);
  assign icr_byte = lane_byte(host_req_i, OFF_INTERRUPT_CONTROL);

  // Write-only command pulses
  assign clr_status   = cmd_wr && cmd_byte[CMD_CLR_STATUS_BIT];
  assign clr_doorbell = cmd_wr && cmd_byte[CMD_CLR_DOORBELL_BIT];

  // Outbound doorbell level, held until software writes zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      send_doorbell_r <= RST_SEND_DOORBELL;
    end else if (ce_i && cmd_wr) begin
      send_doorbell_r <= cmd_byte[CMD_SEND_DOORBELL_BIT];
    end
  end

  // Interrupt enables and outbound line select
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      normal_en_r <= RST_NORMAL_EN;
      error_en_r  <= RST_ERROR_EN;
      line_sel_r  <= RST_LINE_SELECT;
    end else if (ce_i && icr_wr) begin
      normal_en_r <= icr_byte[ICR_NORMAL_EN_BIT];
      error_en_r  <= icr_byte[ICR_ERROR_EN_BIT];
      line_sel_r  <= icr_byte[ICR_SEL_MSB:0];
    end
  end

  // Sticky error flags; a new event in the clearing cycle wins
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_err_r <= 1'b0;
      bus_err_r  <= 1'b0;
      timeout_r  <= 1'b0;
    end else if (ce_i) begin
      link_err_r <= link_err_evt || (link_err_r && !clr_status);
      bus_err_r  <= bus_err_evt || (bus_err_r && !clr_status);
      timeout_r  <= tmo_set || (timeout_r && !clr_status);
    end
  end

  // Inbound doorbell flag, cleared only by its own command bit
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      doorbell_r <= 1'b0;
    end else if (ce_i) begin
      doorbell_r <= doorbell_evt || (doorbell_r && !clr_doorbell);
    end
  end

  // Route the outbound doorbell; select zero keeps every line quiet
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cable_interrupt_line_o <= '0;
    end else if (ce_i) begin
      for (int i = 1; i <= 7; i++) begin
        cable_interrupt_line_o[i] <= send_doorbell_r &&
                                     (line_sel_r == 3'(i));
      end
    end
  end

  // Host interrupt sources; remote-off is deliberately not an error source
  assign normal_src = doorbell_r || (|pending) || dma_done_i;
  assign error_src  = link_err_r || bus_err_r || timeout_r || dma_check_error_i;

  // Host interrupt, registered so the pin and the active bit agree
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_irq_o <= 1'b0;
    end else if (ce_i) begin
      host_irq_o <= (normal_en_r && normal_src) ||
                    (error_en_r && error_src);
    end
  end

  // Read images of the local registers; write-only bits read as zero
  assign rd_cmd  = 8'(send_doorbell_r) << CMD_SEND_DOORBELL_BIT;
  assign rd_icr  = (8'(host_irq_o) << ICR_ACTIVE_BIT) |
                   (8'(normal_en_r) << ICR_NORMAL_EN_BIT) |
                   (8'(error_en_r) << ICR_ERROR_EN_BIT) |
                   {5'h00, line_sel_r};
  assign rd_sts  = (8'(link_err_r) << STS_LINK_ERR_BIT) |
                   (8'(bus_err_r) << STS_BUS_ERR_BIT) |
                   (8'(doorbell_r) << STS_DOORBELL_BIT) |
                   (8'(timeout_r) << STS_TIMEOUT_BIT) |
                   (8'(remote_off) << STS_REMOTE_OFF_BIT);
  assign rd_pend = {pending, 1'b0};

  // Timeout window only runs while a remote answer is awaited
  hsni_tmo u_tmo (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .run_i     (ra_state_r == RA_WAIT),
    .expire_o  (expire)
  );

  // A dead remote fails at once rather than burning the whole window
  assign tmo_set = ((ra_state_r == RA_WAIT) && expire && !ack_s2_r) ||
                   (take && is_remote && remote_off);

  // Remote access sequencer: four-phase handshake with the remote card
  always_comb begin
    ra_state_nxt = ra_state_r;
    case (ra_state_r)
      RA_IDLE: begin
        if (take && is_remote && !remote_off) begin
          ra_state_nxt = RA_WAIT;
        end
      end
      RA_WAIT: begin
        if (ack_s2_r || expire) begin
          ra_state_nxt = RA_REL;
        end
      end
      RA_REL: begin
        if (!ack_s2_r) begin
          ra_state_nxt = RA_IDLE;
        end
      end
      default: begin
        ra_state_nxt = RA_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ra_state_r <= RA_IDLE;
    end else if (ce_i) begin
      ra_state_r <= ra_state_nxt;
    end
  end

  // Remote request lines; the request drops on answer or on timeout
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      remote_req_o   <= 1'b0;
      remote_wr_o    <= 1'b0;
      remote_addr_o  <= '0;
      remote_be_o    <= '0;
      remote_wdata_o <= '0;
    end else if (ce_i) begin
      if ((ra_state_r == RA_IDLE) && (ra_state_nxt == RA_WAIT)) begin
        remote_req_o   <= 1'b1;
        remote_wr_o    <= host_req_i.wr;
        remote_addr_o  <= host_req_i.addr[2:0];
        remote_be_o    <= host_req_i.be;
        remote_wdata_o <= host_req_i.wdata;
      end else if ((ra_state_r == RA_WAIT) && (ack_s2_r || expire)) begin
        remote_req_o   <= 1'b0;
      end
    end
  end

  // Host answer: local and unserved bytes answer next cycle, remote on completion
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_ack_o   <= 1'b0;
      host_err_o   <= 1'b0;
      host_rdata_o <= '0;
    end else if (ce_i) begin
      host_ack_o <= 1'b0;
      host_err_o <= 1'b0;
      if (take && !is_remote) begin
        host_ack_o   <= 1'b1;
        host_err_o   <= !is_space;
        host_rdata_o <= '0;
        if (is_local && !host_req_i.wr) begin
          case (host_req_i.addr[5:1])
            5'h00:   host_rdata_o <= {rd_icr, rd_cmd};
            5'h01:   host_rdata_o <= {rd_pend, rd_sts};
            default: host_rdata_o <= '0;
          endcase
        end
      end else if (take && remote_off) begin
        host_ack_o   <= 1'b1;
        host_err_o   <= 1'b1;
        host_rdata_o <= '0;
      end else if (ra_state_r == RA_WAIT && ack_s2_r) begin
        host_ack_o   <= 1'b1;
        host_rdata_o <= remote_wr_o ? 16'h0000 : rdat_s2_r;
      end else if (ra_state_r == RA_WAIT && expire) begin
        host_ack_o   <= 1'b1;
        host_err_o   <= 1'b1;
        host_rdata_o <= '0;
      end
    end
  end

endmodule : hsni_top
`default_nettype wire

// ### hsni_checker.sv
// Checker for hsni_top: host window answers, remote handshake, cable lines.
// Assumes it is bound to hsni_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module hsni_checker (
  // Clock and reset
  input wire logic                sys_clk_i,
  input wire logic                rst_i,
  input wire logic                ce_i,
  // Host window
  input wire logic                host_valid_i,
  input wire hsni_pkg::hsni_req_t host_req_i,
  input wire logic [15:0]         host_rdata_o,
  input wire logic                host_ack_o,
  input wire logic                host_err_o,
  input wire logic                host_irq_o,
  // Cable side
  input wire logic                remote_req_o,
  input wire logic [2:0]          remote_addr_o,
  input wire logic                remote_ack_i,
  input wire logic [7:1]          cable_interrupt_line_o
);
  import hsni_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic        pend_r;
  logic [2:0]  quiet_r;
  logic [6:0]  last_r;
  logic [10:0] wait_r;
  logic        take;
  logic [5:0]  a;
  // A request counts only once the handshake has settled, as the block ignores others
  assign take = ce_i && host_valid_i && !pend_r && quiet_r == 3'h4;
  assign a    = host_req_i.addr;
  // Open transfer and the last taken request
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
      last_r <= 7'h00;
    end else if (take) begin
      pend_r <= 1'b1;
      last_r <= {host_req_i.wr, a};
    end else if (host_ack_o) begin
      pend_r <= 1'b0;
    end
  end
  // Settling count after the handshake and length of each remote wait
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_r <= 3'h0;
      wait_r  <= 11'h000;
    end else begin
      quiet_r <= (remote_req_o || remote_ack_i) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h4};
      wait_r  <= remote_req_o ? wait_r + 11'h001 : 11'h000;
    end
  end
  sequence s_ack_ok;
    host_ack_o && !host_err_o;
  endsequence
  sequence s_cmd_read;
    take && !host_req_i.wr && a == OFF_LOCAL_COMMAND && $stable(host_irq_o) ##1 $stable(host_irq_o);
  endsequence
  a_local_ack_next: assert property (take && (a < OFF_REMOTE_NODE || a >= OFF_REMOTE_END &&
    a < OFF_SPACE_END) |=> s_ack_ok) else $error("local access not answered"); // Local
  a_unmapped_err: assert property (take && a >= OFF_SPACE_END |=> host_ack_o && host_err_o)
    else $error("unmapped access without error"); // Beyond space
  a_ack_pulse: assert property (host_ack_o |=> !host_ack_o) else $error("ack too long");
  a_remote_answer: assert property ($rose(remote_ack_i) && remote_req_o |-> ##[1:5] s_ack_ok)
    else $error("remote answer not passed on"); // Remote bytes
  a_req_holds: assert property (remote_req_o && !remote_ack_i && wait_r < 11'd1190 |=>
    remote_req_o && $stable(remote_addr_o)) else $error("remote request dropped");
  a_tmo_bound: assert property (wait_r < 11'd1203) else $error("remote wait too long");
  a_tmo_err: assert property ($fell(remote_req_o) && wait_r > 11'd1150 |-> ##[0:2]
    host_ack_o && host_err_o) else $error("timeout without error"); // Timeout
  a_irq_mirror: assert property (s_cmd_read |-> host_rdata_o[15] == host_irq_o)
    else $error("active bit differs from irq"); // Active bit
  a_wo_reads_zero: assert property (host_ack_o && last_r == {1'b0, OFF_LOCAL_COMMAND} |->
    host_rdata_o[7:6] == 2'b00) else $error("clear bits read back");
  a_line_onehot: assert property ($onehot0(cable_interrupt_line_o))
    else $error("several cable lines driven"); // One line chosen
endmodule : hsni_checker
bind hsni_top hsni_checker chk_u (.sys_clk_i, .rst_i, .ce_i, .host_valid_i, .host_req_i,
  .host_rdata_o, .host_ack_o, .host_err_o, .host_irq_o, .remote_req_o, .remote_addr_o,
  .remote_ack_i, .cable_interrupt_line_o);
`default_nettype wire

// ### hsni_remote_model.sv
// Behavioural remote card answering the four-phase node access handshake.
// Assumes the request and its qualifiers come registered from the host side.
`timescale 1ns/10ps
`default_nettype none
module hsni_remote_model (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Request from the host side
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [1:0]  be_i,
  input  wire logic [15:0] wdata_i,
  // Test controls: never answer, extra answer delay
  input  wire logic        mute_i,
  input  wire logic [3:0]  lag_i,
  // Answer
  output logic             ack_o,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [4];
  // Remote node bytes live here; data settles three clocks plus lag_i before ack
  initial begin
    ack_o   = 1'b0;
    rdata_o = 16'h0000;
    mem     = '{16'h1100, 16'h2200, 16'h3300, 16'h4400};
    forever begin
      @(posedge sys_clk_i);
      if (req_i && !rst_i && !mute_i) begin
        if (wr_i && be_i[0]) mem[addr_i[2:1]][7:0] = wdata_i[7:0];
        if (wr_i && be_i[1]) mem[addr_i[2:1]][15:8] = wdata_i[15:8];
        #1 rdata_o = wr_i ? 16'h0000 : mem[addr_i[2:1]];
        repeat (lag_i + 4'h3) @(posedge sys_clk_i);
        #1 ack_o = 1'b1;
        while (req_i) @(posedge sys_clk_i);
        // Released data no longer shows the last value
        #1 ack_o = 1'b0;
        rdata_o = ~rdata_o;
      end
    end
  end
endmodule : hsni_remote_model
`default_nettype wire

// ### hsni_top_tb_top.sv
// Testbench for hsni_top: register window, doorbells, errors, remote path.
// Assumes hsni_remote_model on the cable side and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module hsni_top_tb_top;
  import hsni_pkg::*;
  logic        sys_clk_i, rst_i, vld, ack, err, irq, rreq, rwr, rack, mute, erf;
  logic [2:0]  raddr, off, ev;
  logic [1:0]  rbe, dma;
  logic [3:0]  lag;
  logic [15:0] rdata, rwd, rrd, rd;
  logic [7:1]  cin, cout;
  hsni_req_t   req;
  int          error_cnt, checks, cyc;
  hsni_top dut_u (.sys_clk_i, .rst_i, .ce_i(1'b1), .host_valid_i(vld), .host_req_i(req),
    .host_rdata_o(rdata), .host_ack_o(ack), .host_err_o(err), .host_irq_o(irq),
    .remote_req_o(rreq), .remote_wr_o(rwr), .remote_addr_o(raddr), .remote_be_o(rbe),
    .remote_wdata_o(rwd), .remote_ack_i(rack), .remote_rdata_i(rrd),
    .link_data_err_i(ev[0]), .remote_bus_err_i(ev[1]), .inbound_doorbell_interrupt_i(ev[2]),
    .remote_power_off_i(off[0]), .cable_absent_i(off[1]), .remote_reset_i(off[2]),
    .cable_interrupt_line_i(cin), .cable_interrupt_line_o(cout),
    .dma_done_i(dma[0]), .dma_check_error_i(dma[1]));
  hsni_remote_model far_u (.sys_clk_i, .rst_i, .req_i(rreq), .wr_i(rwr), .addr_i(raddr),
    .be_i(rbe), .wdata_i(rwd), .mute_i(mute), .lag_i(lag), .ack_o(rack), .rdata_o(rrd));
  // Clock at 40 MHz
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // Hang guard, well above the longest scenario
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One register access; pauses afterwards so the handshake and flags settle
  task automatic xfer(input logic w, input logic [5:0] a, input logic [1:0] b,
                      input logic [15:0] d);
    int n;
    n   = 0;
    req = '{w, a, b, d};
    vld = 1'b1;
    @(negedge sys_clk_i);
    vld = 1'b0;
    while (ack !== 1'b1 && n < 2000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 2000) error_cnt++;
    rd  = rdata;
    erf = err;
    repeat (6) @(negedge sys_clk_i);
  endtask : xfer
  task automatic rdw(input logic [5:0] a);
    xfer(1'b0, a, 2'b11, 16'h0000);
  endtask : rdw
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    ev[i] = 1'b0;
    repeat (4) @(negedge sys_clk_i);
  endtask : pulse
  // Every select value with the doorbell raised; clear bits read back as zero
  task automatic t_route();
    for (int s = 0; s < 8; s++) begin
      xfer(1'b1, OFF_LOCAL_COMMAND, 2'b11, {5'h00, 3'(s), 8'hE0});
      chk({9'h000, cout}, s == 0 ? 16'h0000 : 16'(1 << (s - 1))); // Line follows select
    end
    rdw(OFF_LOCAL_COMMAND);
    chk(rd, 16'h0720); // Readback
    xfer(1'b1, OFF_LOCAL_COMMAND, 2'b11, 16'h0000);
    chk({9'h000, cout}, 16'h0000); // Request withdrawn
  endtask : t_route
  task automatic t_doorbell();
    pulse(2);
    rdw(OFF_LOCAL_STATUS);
    chk(rd, 16'h0020); // Doorbell flag
    chk(16'(irq), 16'h0000); // Normal gate shut
    xfer(1'b1, OFF_LOCAL_COMMAND, 2'b11, 16'h4000);
    chk(16'(irq), 16'h0001); // Gate open
    rdw(OFF_LOCAL_COMMAND);
    chk(rd, 16'hC000); // Active bit set
    xfer(1'b1, OFF_LOCAL_COMMAND, 2'b11, 16'h4040);
    rdw(OFF_LOCAL_STATUS);
    chk(rd, 16'h0000); // Doorbell cleared
    rdw(OFF_LOCAL_COMMAND);
    chk(rd, 16'h4000); // Active bit falls
  endtask : t_doorbell
  task automatic t_errors();
    pulse(0);
    pulse(1);
    rdw(OFF_LOCAL_STATUS);
    chk(rd, 16'h00C0); // Both errors latched
    chk(16'(irq), 16'h0000); // Error gate shut
    xfer(1'b1, OFF_LOCAL_COMMAND, 2'b10, 16'h2000);
    chk(16'(irq), 16'h0001); // Error gate open
    xfer(1'b1, OFF_LOCAL_COMMAND, 2'b01, 16'h0080);
    rdw(OFF_LOCAL_STATUS);
    chk(rd, 16'h0000); // Errors cleared
    chk(16'(irq), 16'h0000); // Irq follows source
    dma = 2'b10;
    repeat (3) @(negedge sys_clk_i);
    chk(16'(irq), 16'h0001); // Check error gated
    xfer(1'b1, OFF_LOCAL_COMMAND, 2'b11, 16'h4000);
    chk(16'(irq), 16'h0000); // Error gate shut again
    dma = 2'b01;
    cin = 7'h55; // Lines 1, 3, 5 and 7 raised
    repeat (2) @(negedge sys_clk_i);
    rdw(OFF_LOCAL_STATUS);
    chk(rd, 16'hAA00); // Pending lines, bit 0 zero
    chk(16'(irq), 16'h0001); // Normal sources gated
    cin = 7'h00;
    dma = 2'b00;
  endtask : t_errors
  // Remote path both ways, a byte lane, a slow answer, then a timeout
  task automatic t_remote();
    xfer(1'b1, OFF_REMOTE_NODE, 2'b11, 16'h5AA5);
    xfer(1'b1, 6'h0C, 2'b01, 16'hBBEE);
    lag = 4'h9;
    rdw(OFF_REMOTE_NODE);
    chk(rd, 16'h5AA5); // Remote word
    rdw(6'h0C);
    chk(rd, 16'h33EE); // One byte written
    mute = 1'b1;
    rdw(6'h0A);
    chk(16'(erf), 16'h0001); // Timed out
    mute = 1'b0;
    rdw(OFF_LOCAL_STATUS);
    chk(rd, 16'h0004); // Timeout flag
    rdw(OFF_REMOTE_NODE); // Flush read, value ignored
    xfer(1'b1, OFF_LOCAL_COMMAND, 2'b11, 16'h2080);
    rdw(OFF_LOCAL_STATUS);
    chk(rd, 16'h0000); // Timeout cleared
  endtask : t_remote
  task automatic t_remote_off();
    for (int i = 0; i < 3; i++) begin
      off = 3'(1 << i);
      repeat (2) @(negedge sys_clk_i);
      rdw(OFF_LOCAL_STATUS);
      chk(rd, 16'h0001); // Remote down shown
      chk(16'(irq), 16'h0000); // No error irq
      rdw(OFF_REMOTE_NODE);
      chk(16'(erf), 16'h0001); // Access fails
      off = 3'h0;
      xfer(1'b1, OFF_LOCAL_COMMAND, 2'b11, 16'h2080);
      rdw(OFF_LOCAL_STATUS);
      chk(rd, 16'h0000); // Clears by itself
    end
  endtask : t_remote_off
  task automatic t_map();
    rdw(OFF_SPACE_END);
    chk(16'(erf), 16'h0001); // Outside space
    xfer(1'b1, OFF_LOCAL_STATUS, 2'b11, 16'hFFFF);
    rdw(OFF_LOCAL_STATUS);
    chk(rd, 16'h0000); // Read-only kept
    rdw(OFF_REMOTE_END);
    chk({erf, rd[14:0]}, 16'h0000); // Not held here
  endtask : t_map
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  // Reset for three cycles, then the scenarios
  initial begin
    {vld, mute, lag, off, ev, dma, cin, req, error_cnt, checks, cyc} = '0;
    rst_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    rdw(OFF_LOCAL_COMMAND);
    chk(rd, 16'h0000); // Reset values
    t_route();
    t_doorbell();
    t_errors();
    t_remote();
    t_remote_off();
    t_map();
    test_done();
  end
endmodule : hsni_top_tb_top
`default_nettype wire
